// File: ccs_defines.svh
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// Register byte offsets on the AXI4-Lite bus
`define CCS_OFF_CTRL 8'h00
`define CCS_OFF_INT_STATUS 8'h04
`define CCS_OFF_INT_ENABLE 8'h08
`define CCS_OFF_INT_CLEAR 8'h0C

// Field positions in the control/status register
`define CCS_BIT_ON 7
`define CCS_BIT_RESULT 6
`define CCS_BIT_RISE 5
`define CCS_BIT_FALL 4
`define CCS_POS_HI 3
`define CCS_POS_LO 2
`define CCS_NEG_HI 1
`define CCS_NEG_LO 0

// Field positions in the interrupt status, enable and clear registers
`define CCS_INT_RISE 0
`define CCS_INT_FALL 1

// Reset values
`define CCS_CTRL_RST 8'h00
`define CCS_INT_RST 2'h0
`define CCS_HYST_RST 2'h0

// Bus responses
`define CCS_RESP_OKAY 2'h0
`define CCS_RESP_SLVERR 2'h2

`endif

// File: ccs_pkg.sv
package ccs_pkg;

  // Two-bit hysteresis select, passed to the analog core unchanged
  typedef logic [1:0] ccs_hyst_t;

  // Known hysteresis codes; other codes pass through as written
  typedef enum logic [1:0] {
    CCS_HYST_2MV = 2'h0,
    CCS_HYST_10MV = 2'h2,
    CCS_HYST_10MV_ALT = 2'h3
  } ccs_hyst_e;

  // Write channel state, one-hot
  typedef enum logic [2:0] {
    CCS_WS_COLLECT = 3'h1,
    CCS_WS_EXEC = 3'h2,
    CCS_WS_RESP = 3'h4
  } ccs_wstate_e;

  // Read channel state, one-hot
  typedef enum logic [1:0] {
    CCS_RS_IDLE = 2'h1,
    CCS_RS_DATA = 2'h2
  } ccs_rstate_e;

  typedef logic [7:0] ccs_addr_t;
  typedef logic [31:0] ccs_data_t;

endpackage : ccs_pkg

// File: ccs_edge_sync.sv
`timescale 1ns/1ns
`default_nettype none

module ccs_edge_sync
(
  input wire logic clk,
  input wire logic rst,
  input wire logic raw_in,
  output logic level_out,
  output logic rise_out,
  output logic fall_out
);

  logic meta_q;
  logic sync_q;
  logic prev_q;

  // Two-flop synchroniser; only sync_q reads meta_q
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end
    else
    begin
      meta_q <= raw_in;
      sync_q <= meta_q;
    end
  end

  // Delayed copy for edge detection on the settled level
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_q <= 1'b0;
    end
    else
    begin
      prev_q <= sync_q;
    end
  end

  // One pulse per settled transition, never both at once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rise_out <= 1'b0;
      fall_out <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      rise_out <= sync_q & ~prev_q;
      fall_out <= ~sync_q & prev_q;
      level_out <= sync_q;
    end
  end

endmodule : ccs_edge_sync

`default_nettype wire

// File: ccs_comparator_ctrl.sv
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "ccs_defines.svh"

// Functional notes
// R1 - Bit 7 switches comparator on/off
// R2 - Bit 6 reads comparator output, read-only
// R3 - Bit 5 set on low-to-high output edge
// R4 - Bit 4 set on high-to-low output edge
// R5 - Edge flags stay set until software clears
// R6 - Bits 3:2 select positive hysteresis
// R7 - Bits 1:0 select negative hysteresis
// R8 - Synchronise raw output before edge detection
module ccs_comparator_ctrl
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CMP_RAW,
  output logic CMP_ON,
  output ccs_pkg::ccs_hyst_t CMP_POS_HYST,
  output ccs_pkg::ccs_hyst_t CMP_NEG_HYST,
  output logic IRQ,
  input wire ccs_pkg::ccs_addr_t AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire ccs_pkg::ccs_data_t WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire ccs_pkg::ccs_addr_t ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output ccs_pkg::ccs_data_t RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  import ccs_pkg::*;

  // Address decode shared by the write and read paths
  function automatic logic addr_mapped(input ccs_addr_t a);
    addr_mapped = (a == `CCS_OFF_CTRL) || (a == `CCS_OFF_INT_STATUS) ||
                  (a == `CCS_OFF_INT_ENABLE) || (a == `CCS_OFF_INT_CLEAR);
  endfunction : addr_mapped

  // Control register fields
  logic on_q;
  ccs_hyst_t pos_hyst_q;
  ccs_hyst_t neg_hyst_q;
  logic rise_flag_q;
  logic rise_flag_d;
  logic fall_flag_q;
  logic fall_flag_d;

  // Interrupt block
  logic [1:0] int_status_q;
  logic [1:0] int_status_d;
  logic [1:0] int_enable_q;
  logic irq_q;

  // Synchronised comparator view
  logic result_lvl;
  logic rise_pulse;
  logic fall_pulse;
  logic rise_evt;
  logic fall_evt;

  // Write channel
  ccs_wstate_e wstate_q;
  logic aw_held_q;
  logic w_held_q;
  ccs_addr_t waddr_q;
  ccs_data_t wdata_q;
  logic [3:0] wstrb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic aw_take;
  logic w_take;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_enable;
  logic wr_clear;

  // Read channel
  ccs_rstate_e rstate_q;
  logic arready_q;
  logic rvalid_q;
  ccs_data_t rdata_q;
  logic [1:0] rresp_q;
  logic [7:0] ctrl_view;
  ccs_data_t rd_word;

  // R8 - synchronise raw output
  ccs_edge_sync u_sync
  (
    .clk(MCLK),
    .rst(RST),
    .raw_in(CMP_RAW),
    .level_out(result_lvl),
    .rise_out(rise_pulse),
    .fall_out(fall_pulse)
  );

  // Edges only count while the core is on; a disabled core output is meaningless
  assign rise_evt = rise_pulse & on_q;
  assign fall_evt = fall_pulse & on_q;

  // Handshake terms
  assign aw_take = AWVALID & awready_q;
  assign w_take = WVALID & wready_q;

  // Write strobes, valid only in the execute cycle and for byte lane 0
  assign wr_lane0 = (wstate_q == CCS_WS_EXEC) & wstrb_q[0];
  assign wr_ctrl = wr_lane0 & (waddr_q == `CCS_OFF_CTRL);
  assign wr_enable = wr_lane0 & (waddr_q == `CCS_OFF_INT_ENABLE);
  assign wr_clear = wr_lane0 & (waddr_q == `CCS_OFF_INT_CLEAR);

  // Write channel state; address and data may arrive in either order
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      wstate_q <= CCS_WS_COLLECT;
    end
    else
    begin
      case (wstate_q)
        CCS_WS_COLLECT:
        begin
          if ((aw_held_q | aw_take) & (w_held_q | w_take))
          begin
            wstate_q <= CCS_WS_EXEC;
          end
        end
        CCS_WS_EXEC:
        begin
          wstate_q <= CCS_WS_RESP;
        end
        CCS_WS_RESP:
        begin
          if (BREADY)
          begin
            wstate_q <= CCS_WS_COLLECT;
          end
        end
        default:
        begin
          wstate_q <= CCS_WS_COLLECT;
        end
      endcase
    end
  end

  // Capture the write address and drop ready once it is held
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      aw_held_q <= 1'b0;
      waddr_q <= 8'h00;
      awready_q <= 1'b0;
    end
    else if (aw_take)
    begin
      aw_held_q <= 1'b1;
      waddr_q <= AWADDR;
      awready_q <= 1'b0;
    end
    else if (wstate_q == CCS_WS_RESP && BREADY)
    begin
      aw_held_q <= 1'b0;
      awready_q <= 1'b1;
    end
    else
    begin
      awready_q <= (wstate_q == CCS_WS_COLLECT) & ~aw_held_q;
    end
  end

  // Capture the write data and strobes the same way
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      w_held_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      wready_q <= 1'b0;
    end
    else if (w_take)
    begin
      w_held_q <= 1'b1;
      wdata_q <= WDATA;
      wstrb_q <= WSTRB;
      wready_q <= 1'b0;
    end
    else if (wstate_q == CCS_WS_RESP && BREADY)
    begin
      w_held_q <= 1'b0;
      wready_q <= 1'b1;
    end
    else
    begin
      wready_q <= (wstate_q == CCS_WS_COLLECT) & ~w_held_q;
    end
  end

  // Write response; unmapped addresses answer SLVERR and change nothing
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= `CCS_RESP_OKAY;
    end
    else if (wstate_q == CCS_WS_EXEC)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_mapped(waddr_q) ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
    end
    else if (bvalid_q & BREADY)
    begin
      bvalid_q <= 1'b0;
    end
  end

  // R1 - enable bit
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      on_q <= 1'(`CCS_CTRL_RST >> `CCS_BIT_ON);
    end
    else if (wr_ctrl)
    begin
      on_q <= wdata_q[`CCS_BIT_ON];
    end
  end

  // R6 - positive hysteresis select
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      pos_hyst_q <= `CCS_HYST_RST;
    end
    else if (wr_ctrl)
    begin
      pos_hyst_q <= wdata_q[`CCS_POS_HI:`CCS_POS_LO];
    end
  end

  // R7 - negative hysteresis select
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      neg_hyst_q <= `CCS_HYST_RST;
    end
    else if (wr_ctrl)
    begin
      neg_hyst_q <= wdata_q[`CCS_NEG_HI:`CCS_NEG_LO];
    end
  end

  // Writing 0 clears a flag, writing 1 leaves it; a same-cycle edge wins
  always_comb
  begin
    // R3 - rising edge sets
    rise_flag_d = rise_flag_q;
    // R5 - sticky until cleared
    if (wr_ctrl && !wdata_q[`CCS_BIT_RISE])
    begin
      rise_flag_d = 1'b0;
    end
    if (rise_evt)
    begin
      rise_flag_d = 1'b1;
    end
    // R4 - falling edge sets
    fall_flag_d = fall_flag_q;
    // R5 - sticky until cleared
    if (wr_ctrl && !wdata_q[`CCS_BIT_FALL])
    begin
      fall_flag_d = 1'b0;
    end
    if (fall_evt)
    begin
      fall_flag_d = 1'b1;
    end
  end

  // Edge flag storage
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rise_flag_q <= 1'b0;
      fall_flag_q <= 1'b0;
    end
    else
    begin
      rise_flag_q <= rise_flag_d;
      fall_flag_q <= fall_flag_d;
    end
  end

  // Interrupt status: cleared by writing 1 to the clear register, set wins over clear
  always_comb
  begin
    int_status_d = int_status_q;
    if (wr_clear)
    begin
      int_status_d = int_status_q & ~wdata_q[1:0];
    end
    int_status_d[`CCS_INT_RISE] = int_status_d[`CCS_INT_RISE] | rise_evt;
    int_status_d[`CCS_INT_FALL] = int_status_d[`CCS_INT_FALL] | fall_evt;
  end

  // Interrupt status and enable storage
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      int_status_q <= `CCS_INT_RST;
      int_enable_q <= `CCS_INT_RST;
    end
    else
    begin
      int_status_q <= int_status_d;
      if (wr_enable)
      begin
        int_enable_q <= wdata_q[1:0];
      end
    end
  end

  // Level interrupt, one cycle behind status so the output stays a flop
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      irq_q <= 1'b0;
    end
    else
    begin
      irq_q <= |(int_status_q & int_enable_q);
    end
  end

  // R2 - result bit is live, not stored
  assign ctrl_view = {on_q, result_lvl, rise_flag_q, fall_flag_q, pos_hyst_q, neg_hyst_q};

  // Read data select; clear register and unmapped space read zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (ARADDR)
      `CCS_OFF_CTRL: rd_word = {24'h00_0000, ctrl_view};
      `CCS_OFF_INT_STATUS: rd_word = {30'h0000_0000, int_status_q};
      `CCS_OFF_INT_ENABLE: rd_word = {30'h0000_0000, int_enable_q};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read channel: one address taken, data held until the master takes it
  always_ff @(posedge MCLK)
  begin
    if (RST)
    begin
      rstate_q <= CCS_RS_IDLE;
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CCS_RESP_OKAY;
    end
    else
    begin
      case (rstate_q)
        CCS_RS_IDLE:
        begin
          arready_q <= 1'b1;
          if (ARVALID && arready_q)
          begin
            rstate_q <= CCS_RS_DATA;
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= addr_mapped(ARADDR) ? `CCS_RESP_OKAY : `CCS_RESP_SLVERR;
          end
        end
        CCS_RS_DATA:
        begin
          if (RREADY)
          begin
            rstate_q <= CCS_RS_IDLE;
            rvalid_q <= 1'b0;
            arready_q <= 1'b1;
          end
        end
        default:
        begin
          rstate_q <= CCS_RS_IDLE;
          rvalid_q <= 1'b0;
        end
      endcase
    end
  end

  // Outputs, all straight from flops
  assign CMP_ON = on_q;
  assign CMP_POS_HYST = pos_hyst_q;
  assign CMP_NEG_HYST = neg_hyst_q;
  assign IRQ = irq_q;
  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;

endmodule : ccs_comparator_ctrl

`default_nettype wire

// File: ccs_front_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccs_front_model
#(
  parameter int OTHER_MV = 6
)
(
  input wire logic clk,
  input wire logic on_i,
  input wire logic [1:0] pos_sel,
  input wire logic [1:0] neg_sel,
  input wire logic signed [15:0] diff_mv,
  output logic raw_o
);
  logic state_q = 1'b0;

  // Codes without a known amount get a plain default
  function automatic int hyst_mv(input logic [1:0] c);
    return (c == 2'h0) ? 2 : (c[1] ? 10 : OTHER_MV);
  endfunction : hyst_mv

  always @(posedge clk)
  begin
    if (on_i && !state_q && diff_mv > hyst_mv(pos_sel))
      state_q <= 1'b1;
    else if (on_i && state_q && -diff_mv > hyst_mv(neg_sel))
      state_q <= 1'b0;
  end

  // Switched off the output is undefined, so show the inverse
  assign raw_o = on_i ? state_q : !state_q;
endmodule : ccs_front_model
`default_nettype wire

// File: ccs_comparator_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module ccs_props
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic CMP_RAW,
  input wire logic CMP_ON,
  input wire ccs_pkg::ccs_hyst_t CMP_POS_HYST,
  input wire ccs_pkg::ccs_hyst_t CMP_NEG_HYST,
  input wire logic IRQ,
  input wire ccs_pkg::ccs_addr_t AWADDR,
  input wire logic AWVALID,
  input wire logic AWREADY,
  input wire ccs_pkg::ccs_data_t WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  input wire logic WREADY,
  input wire logic [1:0] BRESP,
  input wire logic BVALID,
  input wire logic BREADY,
  input wire logic ARVALID,
  input wire logic ARREADY,
  input wire ccs_pkg::ccs_data_t RDATA,
  input wire logic RVALID,
  input wire logic RREADY
);
  import ccs_pkg::*;
  logic raw_q;
  logic [3:0] raw_age_q;
  logic [3:0] wr_age_q;

  // Cycles since the pin moved and since a write was taken, saturating
  always_ff @(posedge MCLK)
  begin
    raw_q <= CMP_RAW;
    if (RST || raw_q != CMP_RAW)
      raw_age_q <= 4'h0;
    else if (raw_age_q != 4'hf)
      raw_age_q <= raw_age_q + 4'h1;
    if (RST || (AWVALID && AWREADY))
      wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf)
      wr_age_q <= wr_age_q + 4'h1;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence wr_both;
    AWVALID && AWREADY && WVALID && WREADY;
  endsequence
  sequence ctl_wr;
    wr_both ##0 (AWADDR == 8'h00 && WSTRB[0]);
  endsequence

  chk_on_follows: assert property (ctl_wr |-> ##2 CMP_ON == $past(WDATA[7], 2))
    else $error("enable output not the written bit");
  chk_pos_hyst: assert property (ctl_wr |-> ##2 CMP_POS_HYST == $past(WDATA[3:2], 2))
    else $error("positive hysteresis not the written code");
  chk_neg_hyst: assert property (ctl_wr |-> ##2 CMP_NEG_HYST == $past(WDATA[1:0], 2))
    else $error("negative hysteresis not the written code");
  chk_irq_cause: assert property ($rose(IRQ) |-> raw_age_q < 4'h9 || wr_age_q < 4'h6)
    else $error("interrupt rose without a pin edge or write");
  chk_irq_sticky: assert property (IRQ && wr_age_q > 4'h4 |=> IRQ)
    else $error("interrupt dropped without a write");
  chk_write_lat: assert property (wr_both |-> ##1 !BVALID ##1 BVALID)
    else $error("write answer not two cycles after");
  chk_read_lat: assert property (ARVALID && ARREADY |=> RVALID)
    else $error("read answer late");
  chk_b_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write answer not held");
  chk_r_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read answer not held");
endmodule : ccs_props

bind ccs_comparator_ctrl ccs_props chk_u (.*);
`default_nettype wire

// File: comparator_control_status_tb.sv
`timescale 1ns/1ns
`default_nettype none
module comparator_control_status_tb;
  import ccs_pkg::*;
  logic MCLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY;
  logic CMP_RAW, CMP_ON, IRQ, AWREADY, WREADY, BVALID, ARREADY, RVALID;
  ccs_addr_t AWADDR, ARADDR;
  ccs_data_t WDATA, RDATA;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, rsp;
  ccs_hyst_t CMP_POS_HYST, CMP_NEG_HYST;
  logic signed [15:0] diff;
  logic [31:0] seed, rd_d;
  int err_count, compares;
  int m_on, m_out, m_rf, m_ff, m_pos, m_neg, m_st, m_en;
  int steps[5] = '{-20, 5, 12, -5, -12};

  ccs_comparator_ctrl dut_u (.*);
  ccs_front_model fe_u (.clk(MCLK), .on_i(CMP_ON), .pos_sel(CMP_POS_HYST),
    .neg_sel(CMP_NEG_HYST), .diff_mv(diff), .raw_o(CMP_RAW));

  // Free-running clock
  initial
  begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic final_report();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report

  // Ready is raised late at random so the slave must hold its answer
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int dly;
    dly = rnd() % 4;
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge MCLK);
      if (AWREADY)
        AWVALID <= 1'b0;
      if (WREADY)
        WVALID <= 1'b0;
      if (BVALID && BREADY)
      begin
        rsp = BRESP;
        BREADY <= 1'b0;
        return;
      end
      else if (n >= dly)
        BREADY <= 1'b1;
    end
    err_count++;
    final_report();
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a);
    int dly;
    dly = rnd() % 4;
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(posedge MCLK);
      if (ARREADY)
        ARVALID <= 1'b0;
      if (RVALID && RREADY)
      begin
        rd_d = RDATA;
        rsp = RRESP;
        RREADY <= 1'b0;
        return;
      end
      else if (n >= dly)
        RREADY <= 1'b1;
    end
    err_count++;
    final_report();
  endtask : bus_rd

  // Upper lanes carry noise; only lane 0 holds data
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s);
    logic [31:0] r;
    r = rnd();
    bus_wr(a, {r[31:8], v}, s);
    chk("write response", (a[1:0] == 0 && a < 16) ? 2'h0 : 2'h2, rsp);
    if (s[0] && a == 8'h00)
    begin
      m_on = v[7];
      m_rf &= v[5];
      m_ff &= v[4];
      m_pos = v[3:2];
      m_neg = v[1:0];
    end
    if (s[0] && a == 8'h08)
      m_en = v[1:0];
    if (s[0] && a == 8'h0c)
      m_st &= ~v[1:0];
  endtask : reg_wr

  // Moves the input and predicts the edge flags from the hysteresis codes
  task automatic drive(input int mv);
    @(posedge MCLK);
    diff <= mv[15:0];
    if (m_on && !m_out && mv > (m_pos == 0 ? 2 : 10))
    begin
      m_out = 1;
      m_rf = 1;
      m_st |= 1;
    end
    else if (m_on && m_out && -mv > (m_neg == 0 ? 2 : 10))
    begin
      m_out = 0;
      m_ff = 1;
      m_st |= 2;
    end
    repeat (12) @(posedge MCLK);
  endtask : drive

  task automatic check_all(input logic [31:0] mask);
    bus_rd(8'h00);
    chk("control", {m_on[0], m_out[0], m_rf[0], m_ff[0], m_pos[1:0], m_neg[1:0]} & mask,
      rd_d & mask);
    bus_rd(8'h04);
    chk("status", m_st, rd_d);
    bus_rd(8'h08);
    chk("enable", m_en, rd_d);
    chk("irq", (m_st & m_en) != 0, IRQ);
    chk("core", {m_on[0], m_pos[1:0], m_neg[1:0]}, {CMP_ON, CMP_POS_HYST, CMP_NEG_HYST});
  endtask : check_all

  // Main sequence
  initial
  begin
    RST = 1'b1;
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, AWADDR, ARADDR, WDATA, WSTRB} = '0;
    seed = 32'hb2bd_ab02;
    diff = -16'sd20;
    {m_on, m_out, m_rf, m_ff, m_pos, m_neg, m_st, m_en} = '0;
    repeat (6) @(posedge MCLK);
    RST <= 1'b0;
    // Result bit is not defined while off
    check_all(32'hffff_ffbf);
    bus_rd(8'h10);
    chk("read response", 2'h2, rsp);
    chk("unmapped data", 0, rd_d);
    reg_wr(8'h14, 8'hff, 4'hf);
    reg_wr(8'h00, 8'h80, 4'hf);
    repeat (12) @(posedge MCLK);
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(8'h00, {4'h8, i[1] ? 2'h2 : 2'h0, i[0] ? 2'h3 : 2'h0}, 4'hf);
      reg_wr(8'h0c, 8'h03, 4'hf);
      reg_wr(8'h08, {6'h0, seed[1:0]}, 4'hf);
      foreach (steps[k])
      begin
        drive(steps[k]);
        check_all(32'hffff_ffff);
      end
    end
    reg_wr(8'h00, 8'ha0, 4'hf);
    reg_wr(8'h00, 8'h00, 4'he);
    check_all(32'hffff_ffff);
    reg_wr(8'h00, 8'h00, 4'hf);
    reg_wr(8'h0c, 8'h03, 4'hf);
    drive(12);
    drive(-12);
    check_all(32'hffff_ffbf);
    final_report();
  end
endmodule : comparator_control_status_tb
`default_nettype wire
